// *** pcs_defines.svh ***
// Register offsets, field positions, reset values and counts of the port
`ifndef PCS_DEFINES_SVH
`define PCS_DEFINES_SVH

`define PCS_ADR_CTRL        8'h00
`define PCS_ADR_TX_DATA     8'h04
`define PCS_ADR_RX_DATA     8'h08
`define PCS_ADR_STATUS      8'h0C
`define PCS_ADR_FRAME_LEN   8'h10

`define PCS_CTRL_ENABLE     0
`define PCS_CTRL_TX_SW      1
`define PCS_CTRL_RESET      2'h1

`define PCS_ST_TX_BUSY      0
`define PCS_ST_RX_BUSY      1
`define PCS_ST_RX_READY     2
`define PCS_ST_TX_SENT      3
`define PCS_ST_FRAME_ERR    4
`define PCS_ST_POWER_DOWN   5
`define PCS_ST_MSB_FIRST    6
`define PCS_ST_RX_GAIN      7
`define PCS_ST_TX_GAIN      8
`define PCS_ST_BYPASS       9

`define PCS_WORD_BITS       5'h10
`define PCS_MCLK_PER_FRAME  9'h100
`define PCS_FRAME_CNT_MAX   9'h1FF

`endif

// *** pcs_pkg.sv ***
// Types shared by the serial port modules
`default_nettype none
package pcs_pkg;

    typedef enum logic [1:0]
    {
        PCS_IDLE  = 2'b00,
        PCS_ARMED = 2'b01,
        PCS_SHIFT = 2'b10
    } pcs_lane_state_t;

endpackage
`default_nettype wire

// *** pcs_lane.sv ***
// One serial lane: transmit shifter or receive capture of a 16-bit word
`timescale 1ns/1ps
`default_nettype none
`include "pcs_defines.svh"

module pcs_lane
    import pcs_pkg::*;
#(
    parameter bit IS_TX = 1'b1
)
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        enable,
    input  wire logic        sync_fall,
    input  wire logic        mclk_rise,
    input  wire logic        mclk_fall,
    input  wire logic        msb_first,
    input  wire logic [15:0] tx_word,
    input  wire logic        serial_in,
    output logic             serial_out,
    output logic             serial_oe,
    output logic             busy,
    output logic             order_msb,
    output logic             done,
    output logic [15:0]      rx_word
);

    pcs_lane_state_t state;
    logic [4:0]      cnt;
    logic [3:0]      idx;
    logic [4:0]      last;
    logic            step;

    assign idx  = order_msb ? (4'hF - cnt[3:0]) : cnt[3:0];
    assign last = IS_TX ? `PCS_WORD_BITS : (`PCS_WORD_BITS - 5'h01);
    assign step = IS_TX ? mclk_rise : mclk_fall;
    assign busy = (state != PCS_IDLE);

    // Sync fall arms the lane; next master clock fall starts the word
    always_ff @(posedge clk)
    begin
        if (!rst_n || !enable)
        begin
            state     <= PCS_IDLE;
            cnt       <= 5'h00;
            order_msb <= 1'b0;
        end
        else
        begin
            case (state)
                PCS_IDLE:
                begin
                    if (sync_fall)
                        state <= PCS_ARMED;
                end
                PCS_ARMED:
                begin
                    if (mclk_fall)
                    begin
                        state     <= PCS_SHIFT;
                        cnt       <= 5'h00;
                        order_msb <= msb_first;
                    end
                end
                PCS_SHIFT:
                begin
                    if (sync_fall)
                        state <= PCS_ARMED;
                    else if (step)
                    begin
                        if (cnt == last)
                            state <= PCS_IDLE;
                        else
                            cnt <= cnt + 5'h01;
                    end
                end
                default:
                    state <= PCS_IDLE;
            endcase
        end
    end

    // Data path: drive after rising edges, sample on falling edges
    always_ff @(posedge clk)
    begin
        if (!rst_n || !enable)
        begin
            serial_out <= 1'b0;
            serial_oe  <= 1'b0;
            done       <= 1'b0;
            rx_word    <= 16'h0000;
        end
        else
        begin
            done <= 1'b0;
            if (state == PCS_SHIFT && !sync_fall && step)
            begin
                if (IS_TX)
                begin
                    if (cnt == last)
                    begin
                        serial_out <= 1'b0;
                        serial_oe  <= 1'b0;
                        done       <= 1'b1;
                    end
                    else
                    begin
                        serial_out <= tx_word[idx];
                        serial_oe  <= 1'b1;
                    end
                end
                else
                begin
                    rx_word[idx] <= serial_in;
                    if (cnt == last)
                        done <= 1'b1;
                end
            end
            else if (state != PCS_SHIFT)
            begin
                serial_out <= 1'b0;
                serial_oe  <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// *** pcs_serial_port.sv ***
// Serial port of a 16-bit linear voice codec with a Wishbone register file
//
// Added by the designer: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_defines.svh"

module pcs_serial_port
    import pcs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        tx_master_clock,
    input  wire logic        rx_master_clock,
    input  wire logic        tx_frame_sync_n,
    input  wire logic        rx_frame_sync_n,
    input  wire logic        rx_serial_in,
    input  wire logic        bit_order_select,
    input  wire logic        power_down_in,
    input  wire logic        rx_gain_select,
    input  wire logic        tx_gain_select,
    input  wire logic        tx_filter_bypass,
    input  wire logic [14:0] adc_word,
    output logic             tx_serial_out,
    output logic             tx_serial_oe,
    output logic      [14:0] dac_word,
    output logic             dac_load,
    output logic             analog_enable,
    output logic             rx_gain_3db,
    output logic             tx_gain_m3db,
    output logic             tx_filter_bypassed
);

    // Pin samples and their previous values for edge detection
    logic        tx_mclk_q;
    logic        tx_mclk_d;
    logic        rx_mclk_q;
    logic        rx_mclk_d;
    logic        tx_sync_q;
    logic        tx_sync_d;
    logic        rx_sync_q;
    logic        rx_sync_d;
    logic        rx_data_q;
    logic        order_q;
    logic        pd_q;
    logic        rx_gain_q;
    logic        tx_gain_q;
    logic        bypass_q;
    logic        tx_mrise;
    logic        tx_mfall;
    logic        rx_mrise;
    logic        rx_mfall;
    logic        tx_sfall;
    logic        rx_sfall;

    logic [1:0]  ctrl;
    logic [15:0] tx_data;
    logic [15:0] tx_shadow;
    logic [15:0] rx_data;
    logic        rx_ready;
    logic        tx_sent;
    logic        frame_err;
    logic [8:0]  frame_cnt;
    logic [8:0]  frame_len;
    logic        frame_seen;
    logic        active;

    logic        tx_busy;
    logic        tx_order;
    logic        tx_done;
    logic        rx_busy;
    logic        rx_order;
    logic        rx_done;
    logic [15:0] rx_word;
    logic        rx_lane_out;
    logic        rx_lane_oe;

    logic        bus_req;
    logic        wr_en;
    logic [31:0] next_rdata;
    logic [9:0]  status;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            tx_mclk_q <= 1'b0;
            tx_mclk_d <= 1'b0;
            rx_mclk_q <= 1'b0;
            rx_mclk_d <= 1'b0;
            tx_sync_q <= 1'b1;
            tx_sync_d <= 1'b1;
            rx_sync_q <= 1'b1;
            rx_sync_d <= 1'b1;
            rx_data_q <= 1'b0;
            order_q   <= 1'b0;
            pd_q      <= 1'b1;
            rx_gain_q <= 1'b0;
            tx_gain_q <= 1'b0;
            bypass_q  <= 1'b0;
        end
        else
        begin
            tx_mclk_q <= tx_master_clock;
            tx_mclk_d <= tx_mclk_q;
            rx_mclk_q <= rx_master_clock;
            rx_mclk_d <= rx_mclk_q;
            tx_sync_q <= tx_frame_sync_n;
            tx_sync_d <= tx_sync_q;
            rx_sync_q <= rx_frame_sync_n;
            rx_sync_d <= rx_sync_q;
            rx_data_q <= rx_serial_in;
            order_q   <= bit_order_select;
            pd_q      <= power_down_in;
            rx_gain_q <= rx_gain_select;
            tx_gain_q <= tx_gain_select;
            bypass_q  <= tx_filter_bypass;
        end
    end

    assign tx_mrise = tx_mclk_q & ~tx_mclk_d;
    assign tx_mfall = ~tx_mclk_q & tx_mclk_d;
    assign rx_mrise = rx_mclk_q & ~rx_mclk_d;
    assign rx_mfall = ~rx_mclk_q & rx_mclk_d;
    assign tx_sfall = ~tx_sync_q & tx_sync_d;
    assign rx_sfall = ~rx_sync_q & rx_sync_d;
    assign active   = ~pd_q & ctrl[`PCS_CTRL_ENABLE];

    // Word to send is frozen at the sync fall, converter LSB forced to zero
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            tx_shadow <= 16'h0000;
        else if (tx_sfall)
        begin
            if (ctrl[`PCS_CTRL_TX_SW])
                tx_shadow <= {tx_data[15:1], 1'b0};
            else
                tx_shadow <= {adc_word, 1'b0};
        end
    end

    pcs_lane #(.IS_TX(1'b1)) u_tx_lane
    (
        .clk        (clk),
        .rst_n      (rst_n),
        .enable     (active),
        .sync_fall  (tx_sfall),
        .mclk_rise  (tx_mrise),
        .mclk_fall  (tx_mfall),
        .msb_first  (order_q),
        .tx_word    (tx_shadow),
        .serial_in  (1'b0),
        .serial_out (tx_serial_out),
        .serial_oe  (tx_serial_oe),
        .busy       (tx_busy),
        .order_msb  (tx_order),
        .done       (tx_done),
        .rx_word    ()
    );

    pcs_lane #(.IS_TX(1'b0)) u_rx_lane
    (
        .clk        (clk),
        .rst_n      (rst_n),
        .enable     (active),
        .sync_fall  (rx_sfall),
        .mclk_rise  (rx_mrise),
        .mclk_fall  (rx_mfall),
        .msb_first  (order_q),
        .tx_word    (16'h0000),
        .serial_in  (rx_data_q),
        .serial_out (rx_lane_out),
        .serial_oe  (rx_lane_oe),
        .busy       (rx_busy),
        .order_msb  (rx_order),
        .done       (rx_done),
        .rx_word    (rx_word)
    );

    // Converter side of the received word
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rx_data  <= 16'h0000;
            dac_word <= 15'h0000;
            dac_load <= 1'b0;
        end
        else
        begin
            dac_load <= rx_done;
            if (rx_done)
            begin
                rx_data  <= rx_word;
                dac_word <= rx_word[15:1];
            end
        end
    end

    // Static pins steer the analog side
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            analog_enable      <= 1'b0;
            rx_gain_3db        <= 1'b0;
            tx_gain_m3db       <= 1'b0;
            tx_filter_bypassed <= 1'b0;
        end
        else
        begin
            analog_enable      <= active;
            rx_gain_3db        <= active & rx_gain_q;
            tx_gain_m3db       <= active & tx_gain_q & ~bypass_q;
            tx_filter_bypassed <= active & bypass_q;
        end
    end

    // Master clocks per transmit frame, checked against 256
    always_ff @(posedge clk)
    begin
        if (!rst_n || !active)
        begin
            frame_cnt  <= 9'h000;
            frame_len  <= 9'h000;
            frame_seen <= 1'b0;
        end
        else if (tx_sfall)
        begin
            frame_cnt  <= 9'h000;
            frame_len  <= frame_cnt;
            frame_seen <= 1'b1;
        end
        else if (tx_mfall && frame_cnt != `PCS_FRAME_CNT_MAX)
            frame_cnt <= frame_cnt + 9'h001;
    end

    // Wishbone slave: ack one cycle after the request, single pulse
    assign bus_req = wb_cyc_i & wb_stb_i;
    assign wr_en   = bus_req & wb_we_i & wb_ack_o;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= bus_req & ~wb_ack_o;
            if (bus_req && !wb_ack_o)
                wb_dat_o <= next_rdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            ctrl <= `PCS_CTRL_RESET;
        else if (wr_en && wb_adr_i == `PCS_ADR_CTRL && wb_sel_i[0])
            ctrl <= wb_dat_i[1:0];
    end

    genvar b;
    generate
        for (b = 0; b < 2; b = b + 1)
        begin : g_tx_byte
            always_ff @(posedge clk)
            begin
                if (!rst_n)
                    tx_data[b*8 +: 8] <= 8'h00;
                else if (wr_en && wb_adr_i == `PCS_ADR_TX_DATA && wb_sel_i[b])
                    tx_data[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            end
        end
    endgenerate

    // Sticky flags: a new event wins over a write-one clear
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rx_ready  <= 1'b0;
            tx_sent   <= 1'b0;
            frame_err <= 1'b0;
        end
        else
        begin
            if (rx_done)
                rx_ready <= 1'b1;
            else if (wr_en && wb_adr_i == `PCS_ADR_STATUS && wb_sel_i[0]
                     && wb_dat_i[`PCS_ST_RX_READY])
                rx_ready <= 1'b0;
            if (tx_done)
                tx_sent <= 1'b1;
            else if (wr_en && wb_adr_i == `PCS_ADR_STATUS && wb_sel_i[0]
                     && wb_dat_i[`PCS_ST_TX_SENT])
                tx_sent <= 1'b0;
            if (tx_sfall && frame_seen && frame_cnt != `PCS_MCLK_PER_FRAME)
                frame_err <= 1'b1;
            else if (wr_en && wb_adr_i == `PCS_ADR_STATUS && wb_sel_i[0]
                     && wb_dat_i[`PCS_ST_FRAME_ERR])
                frame_err <= 1'b0;
        end
    end

    assign status = {bypass_q, tx_gain_q, rx_gain_q, order_q, pd_q,
                     frame_err, tx_sent, rx_ready, rx_busy, tx_busy};

    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (wb_adr_i == `PCS_ADR_CTRL)
            next_rdata[1:0] = ctrl;
        else if (wb_adr_i == `PCS_ADR_TX_DATA)
            next_rdata[15:0] = {tx_data[15:1], 1'b0};
        else if (wb_adr_i == `PCS_ADR_RX_DATA)
            next_rdata[15:0] = rx_data;
        else if (wb_adr_i == `PCS_ADR_STATUS)
            next_rdata[9:0] = status;
        else if (wb_adr_i == `PCS_ADR_FRAME_LEN)
            next_rdata[8:0] = frame_len;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_TX_RELEASED:
        assert property (!tx_busy |-> !tx_serial_oe)
        else $error("transmit output driven while idle");

    AST_TX_LSB_ZERO:
        assert property (tx_shadow[0] == 1'b0)
        else $error("transmit word LSB not zero");

    AST_TX_FIRST_BIT:
        assert property ($rose(tx_serial_oe) |->
            tx_serial_out == (tx_order ? tx_shadow[15] : tx_shadow[0]))
        else $error("first transmit bit in wrong order");

    AST_TX_CHANGE_RISE:
        assert property ($changed(tx_serial_out) |-> $past(tx_mrise))
        else $error("transmit data changed without rising clock");

    AST_RX_DONE_FALL:
        assert property (rx_done |-> $past(rx_mfall) && $past(rx_busy))
        else $error("receive word ended off a falling clock");

    AST_DAC_UPPER:
        assert property (rx_done |=> dac_load
                         && dac_word == $past(rx_word[15:1]))
        else $error("converter word not upper 15 bits");

    AST_POWER_DOWN:
        assert property (pd_q |=> !tx_serial_oe && !analog_enable
                         && !tx_busy && !rx_busy)
        else $error("device active while powered down");

    AST_RX_GAIN:
        assert property (active && $past(active) |=>
                         rx_gain_3db == $past(rx_gain_q))
        else $error("receive gain does not follow pin");

    AST_TX_BYPASS:
        assert property (active && bypass_q |=>
                         tx_filter_bypassed && !tx_gain_m3db)
        else $error("bypass does not override transmit gain");

    AST_RX_READY_SET:
        assert property (rx_done |=> rx_ready)
        else $error("receive ready flag lost");

    AST_BUS_ACK:
        assert property (bus_req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single pulse");

    COV_TX_WORD:
        cover property (tx_sfall ##[1:300] $rose(tx_serial_oe)
                        ##[1:1000] tx_done);
    COV_RX_WORD:
        cover property (rx_sfall ##[1:900] rx_done);
    COV_MSB_FIRST:
        cover property (tx_order && $rose(tx_serial_oe));
    COV_FRAME_ERR:
        cover property ($rose(frame_err));

endmodule
`default_nettype wire

// *** pcs_dsp_model.sv ***
// Far-end framing logic: master clock, frame sync and serial words
`timescale 1ns/1ps
`default_nettype none
module pcs_dsp_model
#(
    parameter int HALF = 24
)
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [8:0]  frame_len,
    input  wire logic        msb_first,
    input  wire logic [15:0] rx_word,
    input  wire logic        tx_pin,
    input  wire logic        tx_oe,
    output logic             mclk,
    output logic             sync_n,
    output logic             rx_bit,
    output logic      [15:0] tx_word,
    output logic      [4:0]  oe_cnt,
    output logic             tx_got
);
    logic [5:0]  hc;
    logic [8:0]  per;
    logic [4:0]  k;
    logic [15:0] rxw;
    logic [3:0]  rx_idx;
    logic [3:0]  tx_idx;
    logic        in_word;

    assign in_word = (k != 5'h00) && (k <= 5'h10);
    assign rx_idx = msb_first ? 4'(5'h0F - k) : k[3:0];
    assign tx_idx = msb_first ? 4'(5'h10 - k) : 4'(k - 5'h01);

    always_ff @(posedge clk)
    begin
        tx_got <= 1'b0;
        if (!rst_n)
        begin
            hc     <= 6'h00;
            mclk   <= 1'b1;
            sync_n <= 1'b1;
            per    <= 9'h0FC;
            k      <= 5'h1F;
            rx_bit <= 1'b0;
        end
        else
        begin
            hc <= hc + 6'h01;
            // Released line toggles so no stale bit can pass
            if (!in_word)
                rx_bit <= ~rx_bit;
            if (hc == 6'(HALF - 1))
            begin
                hc   <= 6'h00;
                mclk <= ~mclk;
                if (!mclk && per == 9'(frame_len - 9'h001))
                begin
                    per    <= 9'h000;
                    sync_n <= 1'b0;
                    k      <= 5'h00;
                    rxw    <= rx_word;
                    oe_cnt <= 5'h00;
                end
                else if (!mclk)
                begin
                    per <= per + 9'h001;
                    if (k != 5'h1F)
                        k <= k + 5'h01;
                    if (k == 5'h01)
                        sync_n <= 1'b1;
                    if (k < 5'h10)
                        rx_bit <= rxw[rx_idx];
                end
                else if (in_word)
                begin
                    // Released pin reads as pulled high
                    tx_word[tx_idx] <= tx_oe ? tx_pin : 1'b1;
                    oe_cnt <= oe_cnt + 5'(tx_oe);
                    tx_got <= (k == 5'h10);
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** tb.sv ***
// Self-checking bench of the codec serial port
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
begin \
    comparisons++; \
    if ((a) !== (b)) \
    begin \
        err_count++; \
        $display("mismatch t=%0t got %h exp %h", $time, a, b); \
    end \
end
module tb;
    logic        clk, rst_n, cyc, we, ack, mclk, sync_n, rx_bit;
    logic        tx_out, tx_oe, dac_load, ana_en, rx_g3, tx_gm3, tx_byp;
    logic        tx_got;
    logic [7:0]  adr;
    logic [31:0] wdat, rdat, d;
    logic [4:0]  pins, oe_cnt;
    logic [14:0] adc, dac_word;
    logic [8:0]  flen;
    logic [15:0] rx_word_m, tx_word_m, e, r;
    logic [15:0] exp_tx[$];
    logic [15:0] exp_rx[$];
    integer      seed;
    int          err_count, comparisons, loads, f, n;

    pcs_serial_port u_pcs_serial_port (
        .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .tx_master_clock(mclk),
        .rx_master_clock(mclk), .tx_frame_sync_n(sync_n),
        .rx_frame_sync_n(sync_n), .rx_serial_in(rx_bit),
        .bit_order_select(pins[1]), .power_down_in(pins[0]),
        .rx_gain_select(pins[2]), .tx_gain_select(pins[3]),
        .tx_filter_bypass(pins[4]), .adc_word(adc),
        .tx_serial_out(tx_out), .tx_serial_oe(tx_oe), .dac_word(dac_word),
        .dac_load(dac_load), .analog_enable(ana_en), .rx_gain_3db(rx_g3),
        .tx_gain_m3db(tx_gm3), .tx_filter_bypassed(tx_byp));

    pcs_dsp_model u_pcs_dsp_model (
        .clk(clk), .rst_n(rst_n), .frame_len(flen), .msb_first(pins[1]),
        .rx_word(rx_word_m), .tx_pin(tx_out), .tx_oe(tx_oe), .mclk(mclk),
        .sync_n(sync_n), .rx_bit(rx_bit), .tx_word(tx_word_m),
        .oe_cnt(oe_cnt), .tx_got(tx_got));

    always #5 clk = ~clk;

    always @(posedge clk)
        if (dac_load === 1'b1)
            loads++;

    task automatic tally_and_finish();
        if (err_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] v);
        int t;
        cyc  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= v;
        t = 0;
        do
        begin
            @(posedge clk);
            t++;
        end
        while (ack !== 1'b1 && t < 20);
        `CHK(ack, 1'b1)
        d = rdat;
        cyc <= 1'b0;
        @(posedge clk);
    endtask

    // Next frame: pins, source words and sync spacing
    task automatic setup(input int s);
        logic [15:0] txd;
        logic [15:0] rw;
        logic [14:0] a;
        logic        sw;
        txd = 16'($random(seed));
        rw = 16'($random(seed));
        a = 15'($random(seed));
        sw = (s == 3 || s == 4);
        pins <= {3'($random(seed)), s[0], s == 2};
        adc <= a;
        rx_word_m <= rw;
        flen <= (s == 4) ? 9'h0C8 : 9'h100;
        wb(1'b1, 8'h00, {30'h0, sw, 1'b1});
        wb(1'b1, 8'h04, {16'h0, txd});
        if (s != 2)
        begin
            exp_tx.push_back(sw ? {txd[15:1], 1'b0} : {a, 1'b0});
            exp_rx.push_back(rw);
        end
        repeat (5) @(posedge clk);
        wb(1'b0, 8'h0C, 32'h0);
        `CHK(d[9:5], pins)
        `CHK(ana_en, !pins[0])
        `CHK(rx_g3, pins[2] & !pins[0])
        `CHK(tx_gm3, pins[3] & !pins[4] & !pins[0])
        `CHK(tx_byp, pins[4] & !pins[0])
    endtask

    initial
    begin
        clk = 1'b0;
        seed = 32'h8E55;
        rst_n = 1'b0;
        cyc = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        wdat = 32'h0;
        pins = 5'h00;
        adc = 15'h0;
        flen = 9'h100;
        rx_word_m = 16'h0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        wb(1'b0, 8'h00, 32'h0);
        `CHK(d, 32'h1)
        wb(1'b1, 8'h20, 32'hFFFFFFFF);
        wb(1'b0, 8'h20, 32'h0);
        `CHK(d, 32'h0)
        setup(0);
        for (f = 0; f < 6; f++)
        begin
            n = 0;
            while (tx_got !== 1'b1 && n < 20000)
            begin
                @(posedge clk);
                n++;
            end
            repeat (60) @(posedge clk);
            `CHK(tx_oe, 1'b0)
            `CHK(loads, (f == 2) ? 0 : 1)
            if (f == 2)
                `CHK(oe_cnt, 5'h00)
            else
            begin
                e = exp_tx.pop_front();
                r = exp_rx.pop_front();
                `CHK(oe_cnt, 5'h10)
                `CHK(tx_word_m, e)
                `CHK(dac_word, r[15:1])
                wb(1'b0, 8'h08, 32'h0);
                `CHK(d[15:0], r)
                wb(1'b0, 8'h0C, 32'h0);
                `CHK(d[3:2], 2'b11)
                if (f == 1 || f >= 4)
                begin
                    `CHK(d[4], f == 4)
                    wb(1'b0, 8'h10, 32'h0);
                    `CHK(d[8:0], (f == 4) ? 9'h0C8 : 9'h100)
                end
                wb(1'b1, 8'h0C, 32'h1C);
                wb(1'b0, 8'h0C, 32'h0);
                `CHK(d[4:2], 3'h0)
            end
            loads = 0;
            if (f < 5)
                setup(f + 1);
        end
        tally_and_finish();
    end

    initial
    begin
        repeat (80000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
